// [inc/tpr_map.vh]
// Register map, field positions and reset values of the timer prescale block
`ifndef TPR_MAP_VH
`define TPR_MAP_VH
`define TPR_OFF_CTRL2 8'h00
`define TPR_OFF_FLAGS 8'h04
`define TPR_OFF_CHIE 8'h08
`define TPR_OFF_OVF 8'h0c
`define TPR_OFF_CNT 8'h10
`define TPR_OFF_TC7 8'h14
`define TPR_OFF_CFG 8'h18
`define TPR_OFF_CHACC 8'h1c
`define TPR_BIT_OVIE 7
`define TPR_BIT_CRE 3
`define TPR_BIT_PR_HI 2
`define TPR_BIT_PR_LO 0
`define TPR_BIT_OVF 7
`define TPR_BIT_TEN 0
`define TPR_BIT_ACCUMULATOR_ENABLE_BIT 1
`define TPR_BIT_FFCA 2
`define TPR_RST_CTRL2 8'h00
`define TPR_RST_FLAGS 8'h00
`define TPR_RST_CHIE 8'h00
`define TPR_RST_CFG 8'h00
`define TPR_RST_CNT 16'h0000
`define TPR_RST_TC7 16'h0000
`define TPR_CNT_MAX 16'hffff
`endif

// [rtl/tpr_prescaler.v]
// Bus clock prescaler with synchronized factor update
`timescale 1ns/1ns
`default_nettype none
module tpr_prescaler
(
    input wire aclk,
    input wire aresetn,
    input wire [2:0] sel,
    output reg tick
);
    reg [6:0] div_q;
    reg [2:0] act_q;
    reg [6:0] mask;
    always @*
    begin
        mask = (7'h01 << act_q) - 7'h01;
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_q <= 7'h00;
            act_q <= 3'h0;
            tick <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 7'h01;
            tick <= ((div_q & mask) == mask);
            // New factor only lands when every stage is zero
            if (div_q == 7'h7f)
                act_q <= sel;
        end
    end
endmodule // tpr_prescaler
`default_nettype wire

// [rtl/tpr_counter.v]
// Timer counter with compare-seven reset and overflow detect
`timescale 1ns/1ns
`default_nettype none
`include "tpr_map.vh"
module tpr_counter
(
    input wire aclk,
    input wire aresetn,
    input wire tick,
    input wire run,
    input wire cre,
    input wire [15:0] cmp7,
    output reg [15:0] cnt_q,
    output reg ovf_ev,
    output reg cmp7_ev
);
    wire hit = run && (cnt_q == cmp7);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= `TPR_RST_CNT;
            ovf_ev <= 1'b0;
            cmp7_ev <= 1'b0;
        end
        else
        begin
            ovf_ev <= 1'b0;
            cmp7_ev <= 1'b0;
            // Compare reset is a single bus clock, hence period N+1 at divide by one, N*div above
            if (cre && hit && (cnt_q != 16'h0000 || cmp7 == 16'h0000))
            begin
                cnt_q <= 16'h0000;
                cmp7_ev <= (cmp7 != 16'h0000);
            end
            else if (cre && cmp7 == 16'h0000)
                cnt_q <= 16'h0000;
            else if (run && tick)
            begin
                cnt_q <= cnt_q + 16'h0001;
                ovf_ev <= (cnt_q == `TPR_CNT_MAX);
            end
            if (hit && tick && !cre)
                cmp7_ev <= 1'b1;
        end
    end
endmodule // tpr_counter
`default_nettype wire

// [rtl/tpr_top.v]
// Timer prescale, compare reset and channel flags with AXI4-Lite slave
// Notes on behaviour
// - Overflow flag requests interrupt only while overflow enable bit is one.
// - Counter reset enable bit makes channel-7 compare reset the counter.
// - Reset enable with compare value zero holds counter at zero.
// - Compare value 0xFFFF with reset enable never sets overflow flag.
// - Reset-mode period is compare value plus one clock at divide by one, else compare value times divider.
// - Without channel seven, reset enable bit reads zero, writes ignored.
// - Prescale select divides bus clock by two to the field value.
// - New prescale takes effect when all prescale stages are zero.
// - Channel flag sets on capture or compare event of its channel.
// - Writing one clears flag only while timer or accumulator enabled.
// - Writing zero to a flag bit leaves it unchanged.
// - Fast clear: read of an input channel or write of an output channel clears that channel's flag.
// - Flags of absent channels ignore writes and read zero.
// - Overflow flag sets when counter wraps from 0xFFFF to zero.
// - Channel flag interrupts only while its enable bit is set.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "tpr_map.vh"
module tpr_top
#(
    parameter [7:0] CH_PRESENT = 8'hff
)
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [7:0] chan_event,
    input wire [7:0] chan_is_output,
    input wire accumulator_enable_bit,
    output wire [15:0] timer_counter,
    output wire counter_overflow_flag,
    output wire chan_irq,
    output wire ovf_irq
);
    localparam CRE_OK = CH_PRESENT[7];
    ////////////////////////////////////////////////////////////////////////
    reg [7:0] ctrl2_q;
    reg [7:0] flags_q;
    reg [7:0] chie_q;
    reg ovf_q;
    reg [2:0] cfg_q;
    reg [15:0] tc7_q;
    reg [7:0] aw_q;
    reg [31:0] wd_q;
    reg [3:0] ws_q;
    reg aw_has_q;
    reg w_has_q;
    wire tick;
    wire ovf_ev;
    wire cmp7_ev;
    wire [15:0] cnt;
    wire timer_enable_bit = cfg_q[`TPR_BIT_TEN];
    wire clr_ok = timer_enable_bit | cfg_q[`TPR_BIT_ACCUMULATOR_ENABLE_BIT] | accumulator_enable_bit;
    wire ffca = cfg_q[`TPR_BIT_FFCA];
    ////////////////////////////////////////////////////////////////////////
    // One write at a time; address and data are latched in either order
    assign s_axi_awready = !aw_has_q && !s_axi_bvalid;
    assign s_axi_wready = !w_has_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire aw_ok = s_axi_awvalid && s_axi_awready;
    wire w_ok = s_axi_wvalid && s_axi_wready;
    wire ar_ok = s_axi_arvalid && s_axi_arready;
    wire [7:0] waddr = aw_has_q ? aw_q : s_axi_awaddr;
    wire [31:0] wdata = w_has_q ? wd_q : s_axi_wdata;
    wire [3:0] wstrb = w_has_q ? ws_q : s_axi_wstrb;
    wire do_wr = (aw_has_q | aw_ok) && (w_has_q | w_ok);
    wire lane0 = do_wr && wstrb[0];
    function known;
        input [7:0] a;
        begin
            known = (a[7:5] == 3'h0) && (a[1:0] == 2'b00);
        end
    endfunction
    function [7:0] chbit;
        input [7:0] a;
        begin
            chbit = (a == `TPR_OFF_TC7) ? 8'h80 : 8'h00;
        end
    endfunction
    wire wr_ctrl2 = lane0 && waddr == `TPR_OFF_CTRL2;
    wire wr_flags = lane0 && waddr == `TPR_OFF_FLAGS;
    wire wr_chie = lane0 && waddr == `TPR_OFF_CHIE;
    wire wr_ovf = lane0 && waddr == `TPR_OFF_OVF;
    wire wr_cfg = lane0 && waddr == `TPR_OFF_CFG;
    wire wr_tc7 = do_wr && waddr == `TPR_OFF_TC7;
    // Channel access port: index in low data byte, models 0x10..0x1f access
    wire wr_chacc = lane0 && waddr == `TPR_OFF_CHACC;
    wire rd_chacc = ar_ok && s_axi_araddr == `TPR_OFF_CHACC;
    reg [2:0] chsel_q;
    wire [7:0] chmask = 8'h01 << (wr_chacc ? wdata[2:0] : chsel_q);
    ////////////////////////////////////////////////////////////////////////
    tpr_prescaler u_pre
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .sel(ctrl2_q[`TPR_BIT_PR_HI:`TPR_BIT_PR_LO]),
        .tick(tick)
    );
    tpr_counter u_cnt
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .run(timer_enable_bit),
        .cre(ctrl2_q[`TPR_BIT_CRE]),
        .cmp7(tc7_q),
        .cnt_q(cnt),
        .ovf_ev(ovf_ev),
        .cmp7_ev(cmp7_ev)
    );
    ////////////////////////////////////////////////////////////////////////
    reg [7:0] fast_clr;
    reg [7:0] set_ev;
    reg [7:0] sw_clr;
    always @*
    begin
        fast_clr = 8'h00;
        if (ffca && wr_chacc && chan_is_output[wdata[2:0]])
            fast_clr = chmask;
        if (ffca && rd_chacc && !chan_is_output[chsel_q])
            fast_clr = fast_clr | (8'h01 << chsel_q);
        if (ffca && wr_tc7 && chan_is_output[7])
            fast_clr = fast_clr | chbit(waddr);
        sw_clr = (wr_flags && clr_ok) ? wdata[7:0] : 8'h00;
        set_ev = (chan_event | {cmp7_ev, 7'h00}) & CH_PRESENT;
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl2_q <= `TPR_RST_CTRL2;
            flags_q <= `TPR_RST_FLAGS;
            chie_q <= `TPR_RST_CHIE;
            ovf_q <= 1'b0;
            cfg_q <= 3'h0;
            tc7_q <= `TPR_RST_TC7;
            chsel_q <= 3'h0;
        end
        else
        begin
            if (wr_ctrl2)
            begin
                ctrl2_q <= wdata[7:0] & 8'h8f;
                ctrl2_q[`TPR_BIT_CRE] <= wdata[`TPR_BIT_CRE] & CRE_OK;
            end
            if (wr_chie)
                chie_q <= wdata[7:0] & CH_PRESENT;
            if (wr_cfg)
                cfg_q <= wdata[2:0];
            if (wr_tc7 && CH_PRESENT[7])
                tc7_q <= wdata[15:0];
            if (wr_chacc)
                chsel_q <= wdata[2:0];
            // Set wins over a same-cycle clear
            flags_q <= ((flags_q & ~sw_clr & ~fast_clr) | set_ev)
                & CH_PRESENT;
            // Compare reset leaves by clear, never by increment wrap
            if (ovf_ev)
                ovf_q <= 1'b1;
            else if (wr_ovf && clr_ok && wdata[`TPR_BIT_OVF])
                ovf_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_has_q <= 1'b0;
            w_has_q <= 1'b0;
            aw_q <= 8'h00;
            wd_q <= 32'h00000000;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            if (do_wr)
            begin
                aw_has_q <= 1'b0;
                w_has_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known(waddr) ? 2'b00 : 2'b10;
            end
            else
            begin
                if (aw_ok)
                begin
                    aw_has_q <= 1'b1;
                    aw_q <= s_axi_awaddr;
                end
                if (w_ok)
                begin
                    w_has_q <= 1'b1;
                    wd_q <= s_axi_wdata;
                    ws_q <= s_axi_wstrb;
                end
                if (s_axi_bready)
                    s_axi_bvalid <= 1'b0;
            end
            if (ar_ok)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known(s_axi_araddr) ? 2'b00 : 2'b10;
                case (s_axi_araddr)
                    `TPR_OFF_CTRL2: s_axi_rdata <= {24'h0, ctrl2_q};
                    `TPR_OFF_FLAGS: s_axi_rdata <= {24'h0, flags_q};
                    `TPR_OFF_CHIE: s_axi_rdata <= {24'h0, chie_q};
                    `TPR_OFF_OVF: s_axi_rdata <= {24'h0, ovf_q, 7'h00};
                    `TPR_OFF_CNT: s_axi_rdata <= {16'h0, cnt};
                    `TPR_OFF_TC7: s_axi_rdata <= {16'h0, tc7_q};
                    `TPR_OFF_CFG: s_axi_rdata <= {29'h0, cfg_q};
                    `TPR_OFF_CHACC: s_axi_rdata <= {29'h0, chsel_q};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign timer_counter = cnt;
    assign counter_overflow_flag = ovf_q;
    assign ovf_irq = ovf_q & ctrl2_q[`TPR_BIT_OVIE];
    assign chan_irq = |(flags_q & chie_q);
endmodule // tpr_top
`default_nettype wire

// [sim/tpr_top_assertions.sv]
// Port-level checks for the timer prescale block
`timescale 1ns/1ns
`default_nettype none
module tpr_top_assertions
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] timer_counter,
    input wire logic counter_overflow_flag,
    input wire logic ovf_irq
);
default clocking cb @(posedge aclk);
endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////
ovf_irq_gate_a: assert property (ovf_irq |-> counter_overflow_flag)
    else $error("overflow irq without flag");
ovf_wrap_a: assert property ($rose(counter_overflow_flag) |->
    $past(timer_counter) == 16'hffff || $past(timer_counter, 2) == 16'hffff)
    else $error("overflow flag without wrap");
// Counter only steps by one or returns to zero
cnt_step_a: assert property (!$stable(timer_counter) |->
    timer_counter == $past(timer_counter) + 16'h1 || timer_counter == 16'h0)
    else $error("counter jumped");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
read_excl_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
write_excl_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // tpr_top_assertions
bind tpr_top tpr_top_assertions chk_u
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_counter(timer_counter), .ovf_irq(ovf_irq),
    .counter_overflow_flag(counter_overflow_flag)
);
`default_nettype wire

// [sim/tpr_top_test.sv]
// Self-checking bench for the timer prescale block
`timescale 1ns/1ns
`default_nettype none
module tpr_top_test;
logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, acc_en = 1'b0;
logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev = 8'h00, is_out = 8'h00;
logic [31:0] wdata = 32'h0, rd_q;
logic [1:0] rs_q, bs_q;
wire awready, wready, bvalid, arready, rvalid, ovf_flag, chan_irq, ovf_irq;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [15:0] cnt;
int bad_count = 0, comparisons = 0, cycles = 0;
tpr_top dut_u
(
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chan_event(ev), .chan_is_output(is_out),
    .accumulator_enable_bit(acc_en), .timer_counter(cnt),
    .counter_overflow_flag(ovf_flag), .chan_irq(chan_irq), .ovf_irq(ovf_irq)
);
always #5 aclk = ~aclk;
// Longest test waits one full wrap of the counter at divide by one
always @(posedge aclk)
begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
        bad_count = bad_count + 1;
        close_out;
    end
end
////////////////////////////////////////////////////////////////////////////
task automatic close_out;
    if (bad_count == 0 && comparisons > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons = comparisons + 1;
    if (g !== e)
    begin
        bad_count = bad_count + 1;
        $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
endtask
// Pending flags track each channel, since the driven regs lag by an NBA
task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p, w_p, b_p;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (aw_p || w_p || b_p)
    begin
        @(posedge aclk);
        if (aw_p && awready)
        begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
        end
        if (w_p && wready)
        begin
            wvalid <= 1'b0;
            w_p = 1'b0;
        end
        if (b_p && bvalid)
        begin
            bready <= 1'b0;
            b_p = 1'b0;
            bs_q = bresp;
        end
    end
endtask
task automatic rd(input logic [7:0] a);
    logic ar_p, r_p;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_p = 1'b1;
    r_p = 1'b1;
    while (ar_p || r_p)
    begin
        @(posedge aclk);
        if (ar_p && arready)
        begin
            arvalid <= 1'b0;
            ar_p = 1'b0;
        end
        if (r_p && rvalid)
        begin
            rready <= 1'b0;
            r_p = 1'b0;
            rd_q = rdata;
            rs_q = rresp;
        end
    end
endtask
// Extra edge so the flag update has landed before the caller looks
task automatic pulse(input logic [7:0] e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= 8'h00;
    @(posedge aclk);
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_compare;
    int n;
    wr(8'h00, 32'h08);
    wr(8'h18, 32'h1);
    repeat (40) @(posedge aclk);
    chk("held at zero", 32'h0, {16'h0, cnt});
    wr(8'h14, 32'h4);
    while (cnt != 16'h0004) @(posedge aclk);
    while (cnt != 16'h0000) @(posedge aclk);
    n = 0;
    do
    begin
        @(posedge aclk);
        n++;
    end while (cnt != 16'h0000);
    chk("reset period", 5, n);
    wr(8'h00, 32'h00);
    repeat (20) @(posedge aclk);
    chk("free run", 1, cnt > 16'h0005);
    rd(8'h40);
    chk("unmapped resp", 2, rs_q);
    wr(8'h40, 32'h0);
    chk("unmapped write resp", 2, bs_q);
endtask
task automatic t_prescale;
    int n;
    logic [15:0] c;
    for (int s = 0; s < 8; s++)
    begin
        wr(8'h00, s);
        repeat (260) @(posedge aclk);
        c = cnt;
        while (cnt == c) @(posedge aclk);
        c = cnt;
        n = 0;
        while (cnt == c)
        begin
            @(posedge aclk);
            n++;
        end
        chk("tick period", 1 << s, n);
    end
endtask
task automatic t_flags;
    wr(8'h04, 32'hff);
    wr(8'h18, 32'h0);
    pulse(8'ha5);
    rd(8'h04);
    chk("flags set", 32'ha5, rd_q);
    wr(8'h04, 32'hff);
    rd(8'h04);
    chk("clear disabled", 32'ha5, rd_q);
    wr(8'h18, 32'h1);
    wr(8'h04, 32'h05);
    rd(8'h04);
    chk("clear enabled", 32'ha0, rd_q);
    wr(8'h04, 32'h00);
    rd(8'h04);
    chk("write zero", 32'ha0, rd_q);
    wr(8'h08, 32'h01);
    chk("irq masked", 0, chan_irq);
    pulse(8'h01);
    chk("irq raised", 1, chan_irq);
    wr(8'h18, 32'h0);
    @(posedge aclk);
    acc_en <= 1'b1;
    wr(8'h04, 32'hff);
    rd(8'h04);
    chk("clear by accum", 32'h0, rd_q);
    chk("irq gone", 0, chan_irq);
    @(posedge aclk);
    acc_en <= 1'b0;
endtask
task automatic t_fast;
    wr(8'h18, 32'h5);
    @(posedge aclk);
    is_out <= 8'h8f;
    pulse(8'hff);
    wr(8'h1c, 32'h2);
    rd(8'h04);
    chk("fast write", 32'hfb, rd_q);
    wr(8'h1c, 32'h5);
    rd(8'h1c);
    rd(8'h04);
    chk("fast read", 32'hdb, rd_q);
    wr(8'h14, 32'h4);
    rd(8'h04);
    chk("fast compare", 32'h5b, rd_q);
endtask
task automatic t_ovf;
    wr(8'h18, 32'h1);
    wr(8'h00, 32'h00);
    while (ovf_flag !== 1'b1) @(posedge aclk);
    chk("ovf irq off", 0, ovf_irq);
    wr(8'h00, 32'h80);
    chk("ovf irq on", 1, ovf_irq);
    rd(8'h0c);
    chk("ovf flag", 32'h80, rd_q);
    wr(8'h0c, 32'h80);
    rd(8'h0c);
    chk("ovf cleared", 32'h0, rd_q);
endtask
initial
begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_compare;
    t_prescale;
    t_flags;
    t_fast;
    t_ovf;
    close_out;
end
endmodule // tpr_top_test
`default_nettype wire
